// ### ext_datapath_regs.svh
// constants for the extended instruction datapath
// assumes: included by the package and the design modules
`ifndef EXT_DATAPATH_REGS_SVH
`define EXT_DATAPATH_REGS_SVH
`define DATA_W 8
`define ADDR_W 12
`define BYTE_ONES 8'hff
`define BYTE_ZERO 8'h00
`define BYTE_ONE 8'h01
`define DAA_LOW_ADJ 8'h06
`define DAA_HIGH_ADJ 8'h60
`define NIBBLE_MAX 4'h9
`define SKIP_CYCLES 2'h3
`define OP_W 5
`endif

// ### ext_datapath_pkg.sv
// types for the extended instruction datapath
// assumes: the constants header is on the include path
`include "ext_datapath_regs.svh"
package ext_datapath_pkg;
   typedef enum logic [4:0] {
      ext_decimal_adjust = 5'h00,
      ext_decrement = 5'h01,
      ext_decrement_to_acc = 5'h02,
      ext_increment = 5'h03,
      ext_increment_to_acc = 5'h04,
      ext_move_to_acc = 5'h05,
      ext_move_to_mem = 5'h06,
      ext_or_to_acc = 5'h07,
      ext_or_to_mem = 5'h08,
      ext_rotate_left = 5'h09,
      ext_rotate_left_to_acc = 5'h0a,
      ext_rotate_left_carry = 5'h0b,
      ext_rotate_left_carry_to_acc = 5'h0c,
      ext_rotate_right = 5'h0d,
      ext_rotate_right_to_acc = 5'h0e,
      ext_rotate_right_carry = 5'h0f,
      ext_rotate_right_carry_to_acc = 5'h10,
      ext_sub_borrow_to_acc = 5'h11,
      ext_sub_borrow_to_mem = 5'h12,
      ext_dec_skip_zero = 5'h13,
      ext_dec_skip_zero_to_acc = 5'h14,
      ext_set_ones = 5'h15,
      ext_set_bit = 5'h16,
      ext_inc_skip_zero = 5'h17,
      ext_inc_skip_zero_to_acc = 5'h18,
      ext_skip_bit_nonzero = 5'h19,
      ext_skip_nonzero = 5'h1a
   } op_type;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_exec = 2'b01,
      st_dummy = 2'b10
   } state_type;

   typedef struct packed {
      logic [7:0] sum;
      logic carry_out;
   } daa_type;
endpackage

// ### ext_decimal_adjust_unit.sv
// decimal adjust of the accumulator after a bcd addition
// assumes: flags are the live carry and aux carry of the core
`timescale 1ns/1ps
`include "ext_datapath_regs.svh"
module ext_decimal_adjust_unit
   import ext_datapath_pkg::*;
(
   input wire logic [7:0] i_acc,
   input wire logic i_carry,
   input wire logic i_aux_carry,
   output logic [7:0] o_sum,
   output logic o_carry
);
   logic low_fix;
   logic high_fix;
   logic [8:0] wide;
   always_comb begin
      low_fix = (i_acc[3:0] > `NIBBLE_MAX) || i_aux_carry;
      high_fix = (i_acc[7:4] > `NIBBLE_MAX) || i_carry;
      wide = {1'b0, i_acc} + {1'b0, (low_fix ? `DAA_LOW_ADJ : `BYTE_ZERO)}
         + {1'b0, (high_fix ? `DAA_HIGH_ADJ : `BYTE_ZERO)};
      o_sum = wide[7:0];
      // carry kept for chained decimal sums
      o_carry = wide[8] | i_carry;
   end
endmodule // ext_decimal_adjust_unit

// ### ext_subtract_unit.sv
// subtract with borrow and its flags
// assumes: carry high means no borrow
`timescale 1ns/1ps
`include "ext_datapath_regs.svh"
module ext_subtract_unit
   import ext_datapath_pkg::*;
(
   input wire logic [7:0] i_a,
   input wire logic [7:0] i_b,
   input wire logic i_carry,
   input wire logic i_zero_old,
   output logic [7:0] o_diff,
   output logic o_carry,
   output logic o_aux_carry,
   output logic o_overflow,
   output logic o_zero,
   output logic o_signed_zero,
   output logic o_combined_zero
);
   logic [8:0] wide;
   logic [4:0] low;
   always_comb begin
      // a minus b minus not carry
      wide = {1'b0, i_a} - {1'b0, i_b} - {8'h00, ~i_carry};
      low = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]} - {4'h0, ~i_carry};
      o_diff = wide[7:0];
      o_carry = ~wide[8];
      o_aux_carry = ~low[4];
      o_overflow = (i_a[7] ^ i_b[7]) & (i_a[7] ^ wide[7]);
      o_zero = (wide[7:0] == `BYTE_ZERO);
      o_signed_zero = wide[7] ^ o_overflow;
      // chained zero for multi-byte compares
      o_combined_zero = o_zero & i_zero_old;
   end
endmodule // ext_subtract_unit

// ### extended_instruction_datapath.sv
// execution datapath for the extended data memory instructions
// assumes: the sequencer gives one start pulse per instruction with the
// memory byte already read; memory write takes one cycle
//
// Decided for this implementation: the opcode encoding and the registered memory write strobe.
`timescale 1ns/1ps
`include "ext_datapath_regs.svh"

// How it works
// - decimal adjust adds 00, 06, 60 or 66 to accumulator, writes memory
// - add six per nibble above nine or on its carry flag
// - decrement byte to memory or accumulator, zero flag only
// - increment byte to memory or accumulator, zero flag only
// - moves copy between byte and accumulator, no flags
// - or of accumulator and byte, to either, zero flag only
// - rotate left, top bit into bottom, no flags
// - rotate left through carry, only carry changes
// - rotate right, bottom bit into top, no flags
// - rotate right through carry, only carry changes
// - subtract with borrow, updates six arithmetic flags
// - carry cleared on negative result, set otherwise
// - skip instructions take three cycles, dummy cycle when skipping
// - decrement and skip writes memory, skips on zero, no flags
// - increment and skip writes memory, skips on zero, no flags
// - accumulator skip forms write accumulator, memory untouched
// - set byte writes all ones, set bit forces one bit, no flags
// - skip if selected bit is one, no data or flag change
// - skip if nonzero writes the byte back unchanged
// - skip if byte nonzero, no flag change
// - any data memory address reachable with no section limit
module extended_instruction_datapath
   import ext_datapath_pkg::*;
#(
   parameter int ADDR_W = `ADDR_W
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire op_type i_op,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [2:0] i_bit_sel,
   input wire logic [7:0] i_mem_rdata,
   output logic [7:0] o_accumulator,
   output logic o_carry_flag,
   output logic o_aux_carry_flag,
   output logic o_overflow_flag,
   output logic o_zero_flag,
   output logic o_signed_zero_flag,
   output logic o_combined_zero_flag,
   output logic o_mem_we,
   output logic [ADDR_W-1:0] o_mem_addr,
   output logic [7:0] o_mem_wdata,
   output logic o_skip,
   output logic o_dummy,
   output logic o_busy,
   output logic o_done
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      state_type st;
      logic [1:0] cnt;
      logic [7:0] accumulator_reg;
      logic carry;
      logic aux_carry;
      logic overflow;
      logic zero;
      logic signed_zero;
      logic combined_zero;
      logic mem_we;
      logic [ADDR_W-1:0] mem_addr;
      logic [7:0] mem_wdata;
      logic skip;
      logic dummy;
      logic done;
   } core_type;

   core_type r;
   core_type next_r;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic is_skip_op(input op_type op);
      is_skip_op = (op == ext_dec_skip_zero) || (op == ext_dec_skip_zero_to_acc)
         || (op == ext_inc_skip_zero) || (op == ext_inc_skip_zero_to_acc)
         || (op == ext_skip_bit_nonzero) || (op == ext_skip_nonzero);
   endfunction

   function automatic logic is_zero(input logic [7:0] v);
      is_zero = (v == `BYTE_ZERO);
   endfunction

   // ------------------------------------------------------------
   // arithmetic units
   // ------------------------------------------------------------
   logic [7:0] daa_sum;
   logic daa_carry;
   logic [7:0] sub_diff;
   logic sub_c;
   logic sub_ac;
   logic sub_ov;
   logic sub_z;
   logic sub_sc;
   logic sub_cz;

   ext_decimal_adjust_unit u_daa (
      .i_acc(r.accumulator_reg),
      .i_carry(r.carry),
      .i_aux_carry(r.aux_carry),
      .o_sum(daa_sum),
      .o_carry(daa_carry)
   );

   ext_subtract_unit u_sub (
      .i_a(r.accumulator_reg),
      .i_b(i_mem_rdata),
      .i_carry(r.carry),
      .i_zero_old(r.zero),
      .o_diff(sub_diff),
      .o_carry(sub_c),
      .o_aux_carry(sub_ac),
      .o_overflow(sub_ov),
      .o_zero(sub_z),
      .o_signed_zero(sub_sc),
      .o_combined_zero(sub_cz)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   logic [7:0] m;
   logic [7:0] inc_v;
   logic [7:0] dec_v;
   logic [7:0] or_v;
   logic [7:0] bit_mask;

   always_comb begin
      next_r = r;
      next_r.mem_we = 1'b0;
      next_r.done = 1'b0;
      m = i_mem_rdata;
      inc_v = m + `BYTE_ONE;
      dec_v = m - `BYTE_ONE;
      or_v = r.accumulator_reg | m;
      bit_mask = `BYTE_ONE << i_bit_sel;
      unique case (r.st)
         st_idle: begin
            next_r.skip = 1'b0;
            next_r.dummy = 1'b0;
            if (i_start) begin
               next_r.mem_addr = i_addr;
               next_r.cnt = 2'h1;
               next_r.st = st_exec;
               unique case (i_op)
                  ext_decimal_adjust: begin
                     next_r.mem_wdata = daa_sum;
                     next_r.mem_we = 1'b1;
                     next_r.carry = daa_carry;
                  end
                  ext_decrement: begin
                     next_r.mem_wdata = dec_v;
                     next_r.mem_we = 1'b1;
                     next_r.zero = is_zero(dec_v);
                  end
                  ext_decrement_to_acc: begin
                     next_r.accumulator_reg = dec_v;
                     next_r.zero = is_zero(dec_v);
                  end
                  ext_increment: begin
                     next_r.mem_wdata = inc_v;
                     next_r.mem_we = 1'b1;
                     next_r.zero = is_zero(inc_v);
                  end
                  ext_increment_to_acc: begin
                     next_r.accumulator_reg = inc_v;
                     next_r.zero = is_zero(inc_v);
                  end
                  ext_move_to_acc: begin
                     next_r.accumulator_reg = m;
                  end
                  ext_move_to_mem: begin
                     next_r.mem_wdata = r.accumulator_reg;
                     next_r.mem_we = 1'b1;
                  end
                  ext_or_to_acc: begin
                     next_r.accumulator_reg = or_v;
                     next_r.zero = is_zero(or_v);
                  end
                  ext_or_to_mem: begin
                     next_r.mem_wdata = or_v;
                     next_r.mem_we = 1'b1;
                     next_r.zero = is_zero(or_v);
                  end
                  ext_rotate_left: begin
                     next_r.mem_wdata = {m[6:0], m[7]};
                     next_r.mem_we = 1'b1;
                  end
                  ext_rotate_left_to_acc: begin
                     next_r.accumulator_reg = {m[6:0], m[7]};
                  end
                  ext_rotate_left_carry: begin
                     next_r.mem_wdata = {m[6:0], r.carry};
                     next_r.mem_we = 1'b1;
                     next_r.carry = m[7];
                  end
                  ext_rotate_left_carry_to_acc: begin
                     next_r.accumulator_reg = {m[6:0], r.carry};
                     next_r.carry = m[7];
                  end
                  ext_rotate_right: begin
                     next_r.mem_wdata = {m[0], m[7:1]};
                     next_r.mem_we = 1'b1;
                  end
                  ext_rotate_right_to_acc: begin
                     next_r.accumulator_reg = {m[0], m[7:1]};
                  end
                  ext_rotate_right_carry: begin
                     next_r.mem_wdata = {r.carry, m[7:1]};
                     next_r.mem_we = 1'b1;
                     next_r.carry = m[0];
                  end
                  ext_rotate_right_carry_to_acc: begin
                     next_r.accumulator_reg = {r.carry, m[7:1]};
                     next_r.carry = m[0];
                  end
                  ext_sub_borrow_to_acc, ext_sub_borrow_to_mem: begin
                     if (i_op == ext_sub_borrow_to_acc) begin
                        next_r.accumulator_reg = sub_diff;
                     end else begin
                        next_r.mem_wdata = sub_diff;
                        next_r.mem_we = 1'b1;
                     end
                     next_r.carry = sub_c;
                     next_r.aux_carry = sub_ac;
                     next_r.overflow = sub_ov;
                     next_r.zero = sub_z;
                     next_r.signed_zero = sub_sc;
                     next_r.combined_zero = sub_cz;
                  end
                  ext_dec_skip_zero: begin
                     next_r.mem_wdata = dec_v;
                     next_r.mem_we = 1'b1;
                     next_r.skip = is_zero(dec_v);
                  end
                  ext_dec_skip_zero_to_acc: begin
                     next_r.accumulator_reg = dec_v;
                     next_r.skip = is_zero(dec_v);
                  end
                  ext_inc_skip_zero: begin
                     next_r.mem_wdata = inc_v;
                     next_r.mem_we = 1'b1;
                     next_r.skip = is_zero(inc_v);
                  end
                  ext_inc_skip_zero_to_acc: begin
                     next_r.accumulator_reg = inc_v;
                     next_r.skip = is_zero(inc_v);
                  end
                  ext_set_ones: begin
                     next_r.mem_wdata = `BYTE_ONES;
                     next_r.mem_we = 1'b1;
                  end
                  ext_set_bit: begin
                     next_r.mem_wdata = m | bit_mask;
                     next_r.mem_we = 1'b1;
                  end
                  ext_skip_bit_nonzero: begin
                     next_r.skip = |(m & bit_mask);
                  end
                  ext_skip_nonzero: begin
                     next_r.mem_wdata = m;
                     next_r.mem_we = 1'b1;
                     next_r.skip = !is_zero(m);
                  end
                  default: begin
                     // unknown code finishes with no effect
                     next_r.st = st_idle;
                     next_r.done = 1'b1;
                  end
               endcase
               if (!is_skip_op(i_op)) begin
                  next_r.st = st_idle;
                  next_r.done = 1'b1;
               end
            end
         end
         st_exec: begin
            next_r.cnt = r.cnt + 2'h1;
            if (r.cnt == `SKIP_CYCLES - 2'h2) begin
               next_r.st = st_dummy;
               next_r.dummy = r.skip;
            end
         end
         st_dummy: begin
            next_r.st = st_idle;
            next_r.cnt = 2'h0;
            next_r.dummy = 1'b0;
            next_r.done = 1'b1;
         end
         default: begin
            next_r.st = st_idle;
         end
      endcase
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign o_accumulator = r.accumulator_reg;
   assign o_carry_flag = r.carry;
   assign o_aux_carry_flag = r.aux_carry;
   assign o_overflow_flag = r.overflow;
   assign o_zero_flag = r.zero;
   assign o_signed_zero_flag = r.signed_zero;
   assign o_combined_zero_flag = r.combined_zero;
   assign o_mem_we = r.mem_we;
   assign o_mem_addr = r.mem_addr;
   assign o_mem_wdata = r.mem_wdata;
   assign o_skip = r.skip;
   assign o_dummy = r.dummy;
   // busy is a handshake term for the sequencer
   assign o_busy = (r.st != st_idle);
   assign o_done = r.done;

endmodule // extended_instruction_datapath

// ### ext_datapath_checker_asserts.sv
// concurrent checks on the extended datapath ports
// assumes: bound to the datapath top; one clock, sync reset
`timescale 1ns/1ps
module ext_datapath_checker
   import ext_datapath_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire op_type i_op,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [2:0] i_bit_sel,
   input wire logic [7:0] i_mem_rdata,
   input wire logic [7:0] o_accumulator,
   input wire logic o_carry_flag,
   input wire logic o_aux_carry_flag,
   input wire logic o_overflow_flag,
   input wire logic o_zero_flag,
   input wire logic o_signed_zero_flag,
   input wire logic o_combined_zero_flag,
   input wire logic o_mem_we,
   input wire logic [ADDR_W-1:0] o_mem_addr,
   input wire logic [7:0] o_mem_wdata,
   input wire logic o_skip,
   input wire logic o_dummy,
   input wire logic o_busy,
   input wire logic o_done
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   logic take;
   logic skip_op;
   assign take = i_start && !o_busy;
   assign skip_op = i_op inside {ext_dec_skip_zero, ext_dec_skip_zero_to_acc, ext_inc_skip_zero,
      ext_inc_skip_zero_to_acc, ext_skip_bit_nonzero, ext_skip_nonzero};
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_SKIP_THREE: assert property (
      take && skip_op |=> o_busy [*2] ##1 (o_done && !o_busy))
      else $error("skip op not three cycles");
   AST_DUMMY_SKIP: assert property (
      take && skip_op |=> ##1 (o_dummy == o_skip))
      else $error("dummy cycle differs from skip");
   AST_INC_WRAP: assert property (
      take && i_op == ext_increment |=> o_mem_we && o_mem_wdata == 8'($past(i_mem_rdata) + 8'h01)
      && o_zero_flag == (o_mem_wdata == 8'h00))
      else $error("increment result wrong");
   AST_DEC_ACC: assert property (
      take && i_op == ext_decrement_to_acc |=> !o_mem_we && o_accumulator == 8'($past(i_mem_rdata) - 8'h01))
      else $error("decrement to acc wrong");
   AST_MOVE_FLAGS: assert property (
      take && i_op inside {ext_move_to_acc, ext_move_to_mem} |=> $stable(o_carry_flag)
      && $stable(o_zero_flag) && $stable(o_aux_carry_flag) && $stable(o_overflow_flag))
      else $error("move changed a flag");
   AST_ROT_LEFT: assert property (
      take && i_op == ext_rotate_left |=> o_mem_we && o_mem_wdata == {$past(i_mem_rdata[6:0]), $past(i_mem_rdata[7])})
      else $error("rotate left wrong");
   AST_RRC_ACC: assert property (
      take && i_op == ext_rotate_right_carry_to_acc |=> o_carry_flag == $past(i_mem_rdata[0])
      && o_accumulator == {$past(o_carry_flag), $past(i_mem_rdata[7:1])})
      else $error("rotate right carry wrong");
   AST_SBC_CARRY: assert property (
      take && i_op == ext_sub_borrow_to_acc |=> o_carry_flag == ({1'b0, $past(o_accumulator)}
      >= {1'b0, $past(i_mem_rdata)} + {8'h00, !$past(o_carry_flag)}))
      else $error("subtract carry wrong");
   AST_SNZ_SKIP: assert property (
      take && i_op == ext_skip_nonzero |=> o_mem_we && o_mem_wdata == $past(i_mem_rdata)
      && o_skip == ($past(i_mem_rdata) != 8'h00))
      else $error("skip nonzero wrong");
   AST_SET_ADDR: assert property (
      take && i_op == ext_set_ones |=> o_mem_we && o_mem_addr == $past(i_addr) && o_mem_wdata == 8'hff)
      else $error("set ones wrong");
endmodule // ext_datapath_checker

bind extended_instruction_datapath ext_datapath_checker #(.ADDR_W(ADDR_W)) u_checker (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(i_start), .i_op(i_op), .i_addr(i_addr),
   .i_bit_sel(i_bit_sel), .i_mem_rdata(i_mem_rdata), .o_accumulator(o_accumulator),
   .o_carry_flag(o_carry_flag), .o_aux_carry_flag(o_aux_carry_flag), .o_overflow_flag(o_overflow_flag),
   .o_zero_flag(o_zero_flag), .o_signed_zero_flag(o_signed_zero_flag),
   .o_combined_zero_flag(o_combined_zero_flag), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
   .o_mem_wdata(o_mem_wdata), .o_skip(o_skip), .o_dummy(o_dummy), .o_busy(o_busy), .o_done(o_done));

// ### ext_mem_model.sv
// data memory model beside the datapath
// assumes: read address valid with the start pulse
`timescale 1ns/1ps
module ext_mem_model #(
   parameter int ADDR_W = 12
) (
   input wire logic i_clk,
   input wire logic i_rd,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic i_we,
   input wire logic [ADDR_W-1:0] i_waddr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [0:(1<<ADDR_W)-1];
   // whole address range
   // inverted outside a read, so late sampling shows
   assign o_rdata = i_rd ? mem[i_addr] : ~mem[i_addr];
   always @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end
endmodule // ext_mem_model

// ### test_extended_instruction_datapath.sv
// testbench for the extended instruction datapath
// assumes: memory model beside it; bench plays the sequencer
`timescale 1ns/1ps
module test_extended_instruction_datapath
   import ext_datapath_pkg::*;
;
   localparam logic [11:0] A = 12'hfa5;
   logic i_clk, i_rst_n, i_start, c, ac, ov, z, sz, cz, we, skip, dummy, busy, done, dum_seen, sk_now;
   op_type i_op;
   logic [11:0] i_addr, waddr;
   logic [2:0] i_bit_sel;
   logic [7:0] rdata, acc, wdata;
   int n_fail, tests_run, cyc;
   op_type sop [8] = '{ext_dec_skip_zero, ext_inc_skip_zero, ext_inc_skip_zero_to_acc,
      ext_dec_skip_zero_to_acc, ext_skip_bit_nonzero, ext_skip_bit_nonzero, ext_skip_nonzero, ext_skip_nonzero};
   logic [7:0] sm [8] = '{8'h01, 8'h05, 8'hff, 8'h05, 8'h08, 8'hf7, 8'h00, 8'h40};
   logic [7:0] se [8] = '{8'h00, 8'h06, 8'hff, 8'h05, 8'h08, 8'hf7, 8'h00, 8'h40};
   logic [7:0] sa [8] = '{8'ha5, 8'ha5, 8'h00, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04};
   logic [0:7] sk = 8'b10101001;

   extended_instruction_datapath #(.ADDR_W(12)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_start(i_start), .i_op(i_op), .i_addr(i_addr), .i_bit_sel(i_bit_sel), .i_mem_rdata(rdata),
      .o_accumulator(acc), .o_carry_flag(c), .o_aux_carry_flag(ac), .o_overflow_flag(ov),
      .o_zero_flag(z), .o_signed_zero_flag(sz), .o_combined_zero_flag(cz), .o_mem_we(we),
      .o_mem_addr(waddr), .o_mem_wdata(wdata), .o_skip(skip), .o_dummy(dummy), .o_busy(busy), .o_done(done));
   ext_mem_model #(.ADDR_W(12)) u_mem (.i_clk(i_clk), .i_rd(i_start), .i_addr(i_addr), .i_we(we),
      .i_waddr(waddr), .i_wdata(wdata), .o_rdata(rdata));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chkb(input string nm, input logic e, input logic g);
      chk(nm, {7'h0, e}, {7'h0, g});
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // one instruction; waits for done, then one edge for the memory write
   task automatic run(input op_type op, input logic [7:0] m, input logic [2:0] bs = 3'h0);
      u_mem.mem[A] = m;
      @(posedge i_clk);
      i_start <= 1'b1;
      i_op <= op;
      i_bit_sel <= bs;
      @(posedge i_clk);
      i_start <= 1'b0;
      dum_seen = 1'b0;
      cyc = 0;
      #1;
      while (done !== 1'b1 && cyc < 6) begin
         dum_seen |= dummy;
         @(posedge i_clk);
         #1;
         cyc++;
      end
      if (cyc == 6) begin
         n_fail++;
         summarize();
      end
      sk_now = skip;
      @(posedge i_clk);
      #1;
   endtask
   task automatic daa(input logic [7:0] e, input logic ec);
      run(ext_decimal_adjust, 8'h00);
      chk("daa mem", e, u_mem.mem[A]);
      chkb("daa carry", ec, c);
   endtask

   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      i_rst_n = 1'b0;
      i_start = 1'b0;
      i_op = ext_move_to_acc;
      i_addr = A;
      i_bit_sel = 3'h0;
      n_fail = 0;
      tests_run = 0;
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      run(ext_move_to_acc, 8'h5a);
      chk("move acc", 8'h5a, acc);
      run(ext_move_to_mem, 8'h00);
      chk("move mem", 8'h5a, u_mem.mem[A]);
      run(ext_increment, 8'hff);
      chk("inc mem", 8'h00, u_mem.mem[A]);
      chkb("inc zero", 1'b1, z);
      run(ext_decrement_to_acc, 8'h00);
      chk("dec acc", 8'hff, acc);
      chk("dec mem kept", 8'h00, u_mem.mem[A]);
      run(ext_decrement, 8'h01);
      chk("dec mem", 8'h00, u_mem.mem[A]);
      run(ext_increment_to_acc, 8'h41);
      chk("inc acc", 8'h42, acc);
      $display("test inc dec move done");
      run(ext_move_to_acc, 8'h0f);
      run(ext_or_to_mem, 8'hf0);
      chk("or mem", 8'hff, u_mem.mem[A]);
      run(ext_or_to_acc, 8'h30);
      chk("or acc", 8'h3f, acc);
      chkb("or zero", 1'b0, z);
      run(ext_rotate_left_carry, 8'h80);
      chk("rlc mem", 8'h00, u_mem.mem[A]);
      run(ext_rotate_left_carry_to_acc, 8'h01);
      chk("rlc acc", 8'h03, acc);
      chkb("rlc carry", 1'b0, c);
      run(ext_rotate_right_carry_to_acc, 8'h01);
      chk("rrc acc", 8'h00, acc);
      run(ext_rotate_right_carry, 8'h02);
      chk("rrc mem", 8'h81, u_mem.mem[A]);
      run(ext_rotate_left, 8'h81);
      chk("rl mem", 8'h03, u_mem.mem[A]);
      run(ext_rotate_left_to_acc, 8'h81);
      chk("rl acc", 8'h03, acc);
      run(ext_rotate_right, 8'h81);
      chk("rr mem", 8'hc0, u_mem.mem[A]);
      run(ext_rotate_right_to_acc, 8'h03);
      chk("rr acc", 8'h81, acc);
      chkb("rr carry", 1'b0, c);
      $display("test or rotate done");
      run(ext_move_to_acc, 8'h80);
      run(ext_rotate_left_carry, 8'h80);
      run(ext_sub_borrow_to_acc, 8'h01);
      chk("sbc acc", 8'h7f, acc);
      chkb("sbc ov", 1'b1, ov);
      chkb("sbc ac", 1'b0, ac);
      chkb("sbc sz", 1'b1, sz);
      run(ext_sub_borrow_to_mem, 8'h80);
      chk("sbc mem", 8'hff, u_mem.mem[A]);
      chkb("sbc neg carry", 1'b0, c);
      chkb("sbc mem ac", 1'b1, ac);
      run(ext_sub_borrow_to_acc, 8'h7e);
      chk("sbc zero acc", 8'h00, acc);
      chkb("sbc zero", 1'b1, z);
      chkb("sbc cz first", 1'b0, cz);
      chkb("sbc pos carry", 1'b1, c);
      run(ext_sub_borrow_to_acc, 8'h00);
      chkb("sbc cz chained", 1'b1, cz);
      $display("test subtract done");
      run(ext_move_to_acc, 8'h12);
      daa(8'h78, 1'b1);
      run(ext_rotate_left_carry, 8'h00);
      daa(8'h18, 1'b0);
      run(ext_sub_borrow_to_acc, 8'h03);
      daa(8'h74, 1'b1);
      run(ext_rotate_left_carry, 8'h00);
      daa(8'h14, 1'b0);
      run(ext_move_to_acc, 8'h12);
      daa(8'h12, 1'b0);
      run(ext_move_to_acc, 8'ha5);
      daa(8'h05, 1'b1);
      $display("test decimal adjust done");
      for (int i = 0; i < 8; i++) begin
         run(sop[i], sm[i], 3'h3);
         chk("skip cycles", 8'h02, 8'(cyc));
         chkb("skip", sk[i], sk_now);
         chkb("dummy", sk[i], dum_seen);
         chk("skip mem", se[i], u_mem.mem[A]);
         chk("skip acc", sa[i], acc);
      end
      chkb("skip carry kept", 1'b1, c);
      $display("test skips done");
      run(ext_set_ones, 8'h12);
      chk("set ones", 8'hff, u_mem.mem[A]);
      run(ext_set_bit, 8'h01, 3'h7);
      chk("set bit", 8'h81, u_mem.mem[A]);
      chkb("set carry kept", 1'b1, c);
      $display("test set done");
      summarize();
   end
endmodule // test_extended_instruction_datapath
